// *** rtl/pss_pkg.sv ***
package pss_pkg;
	// Internal oscillator clock rate.
	localparam int unsigned CLK_HZ = 40_000_000;
	// Soft-start length in microseconds and fault timer in milliseconds.
	localparam int unsigned SOFT_START_US = 14_000;
	localparam int unsigned FAULT_TIME_MS = 200;
	// Cycles for the whole ramp; rounded down so the ramp is never longer than nominal.
	localparam int unsigned SOFT_START_CYC = (CLK_HZ / 1_000_000) * SOFT_START_US;
	localparam int unsigned STEPS = 128;
	localparam int unsigned STEP_CYC = SOFT_START_CYC / STEPS;
	localparam int unsigned FAULT_CYC = (CLK_HZ / 1_000) * FAULT_TIME_MS;
	// Soft-start code widths and end points.
	localparam int unsigned CODE_W = 7;
	localparam logic [6:0] CODE_ZERO = 7'h00;
	localparam logic [6:0] CODE_FULL = 7'h7F;
	// Gate-low floor code for 250mV on a 1.25V full scale: 127 * 0.25 / 1.25.
	localparam logic [6:0] CODE_LOW_FLOOR = 7'h19;
	localparam int unsigned DIV_W = 14;
	localparam int unsigned FT_W = 24;
	localparam logic [6:0] STEP_LAST = 7'h7F;
	// Sequencer states.
	typedef enum logic [2:0] {
		PSS_IDLE = 3'b000,
		PSS_RAMP = 3'b001,
		PSS_WAIT_REG = 3'b010,
		PSS_DELAY = 3'b011,
		PSS_RUN = 3'b100,
		PSS_FAULT = 3'b101
	} pss_state_e;
endpackage

// *** rtl/pss_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a bundle of comparator levels.
module pss_sync2 #(
	parameter int unsigned W = 8
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_r <= '0;
			q_r <= '0;
		end else if (en_i) begin
			meta_r <= d_i;
			q_r <= meta_r;
		end
	end
	assign q_o = q_r;
endmodule // pss_sync2
`default_nettype wire

// *** rtl/pss_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RL1) Reference above 1.0V enables step-up and both gate regulators together.
// (RL2) Step-up and gate-high codes ramp 0 to full in 128 steps.
// (RL3) Gate-low code ramps down from full to 250mV code in 128 steps.
// (RL4) Ramps take 14ms; delay node held to ground during ramps.
// (RL5) Each gate regulator enable restarts its ramp from the start code.
// (RL6) All three in regulation releases delay node and starts charge current.
// (RL7) Delay node above 1.25V enables switch block and amplifiers.
// (RL8) Before startup and under lockout the delay node stays grounded.
// (RL9) Steering ignored unless lockout clear, ramps done, no fault, delay reached.
// (RL10) Steering high closes high-side switch; low closes low-side switch.
// (RL11) In steady state any low regulator output runs the fault timer.
// (RL12) Faults lasting 200ms latch fault and disable all but the reference.
// (RL13) Only a supply power cycle through lockout clears the fault latch.
// (RL14) Fault timing is inhibited while any ramp runs.
// (RL15) Over-temperature latches the fault at once and disables all outputs.
// (RL16) Start above lockout; under lockout everything off, amplifiers tri-stated.
// (RL17) Comparators pass two flip-flops; ramp step rate from the clock.
module pss_sequencer
	import pss_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = STEP_CYC,
	parameter int unsigned FAULT_CYCLES = FAULT_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic ref_ready_i,
	input wire logic stepup_ok_i,
	input wire logic gate_high_ok_i,
	input wire logic gate_low_ok_i,
	input wire logic delay_reached_i,
	input wire logic over_temp_i,
	input wire logic switch_steer_i,
	output logic stepup_en_o,
	output logic gate_high_en_o,
	output logic gate_low_en_o,
	output logic [6:0] stepup_code_o,
	output logic [6:0] gate_high_code_o,
	output logic [6:0] gate_low_code_o,
	output logic delay_cap_node_short_o,
	output logic delay_charge_en_o,
	output logic switch_block_en_o,
	output logic amp_en_o,
	output logic amp_hiz_o,
	output logic high_side_switch_o,
	output logic low_side_switch_o,
	output logic fault_latched_o
);
	// Reset is the supply lockout: its release is startup, its assertion is a power cycle.
	typedef struct packed {
		pss_state_e st;
		logic [6:0] up_code;
		logic [6:0] dn_code;
		logic [6:0] step_n;
		logic [DIV_W-1:0] div;
		logic [FT_W-1:0] ftim;
		logic fault;
		logic hs;
		logic ls;
	} pss_state_s;

	pss_state_s s_r;
	pss_state_s s_nxt;
	logic [5:0] syn;
	logic ref_ok;
	logic all_ok;
	logic any_low;
	logic del_ok;
	logic hot;
	logic steer;
	logic steer_ok;

	// Comparator levels are asynchronous to the oscillator.
	pss_sync2 #(.W(6)) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.en_i(ce_i),
		.d_i({ref_ready_i, stepup_ok_i, gate_high_ok_i, gate_low_ok_i,
			delay_reached_i, over_temp_i}),
		.q_o(syn)
	); // see (RL17)

	assign ref_ok = syn[5];
	assign all_ok = syn[4] & syn[3] & syn[2];
	assign any_low = ~all_ok;
	assign del_ok = syn[1];
	assign hot = syn[0];
	assign steer = switch_steer_i;

	// Returns true when the step divider has reached its terminal count.
	function automatic logic div_done(input logic [DIV_W-1:0] d);
		return d == DIV_W'(STEP_CYCLES - 1);
	endfunction

	// Next-state logic for the whole sequencer.
	always_comb begin
		s_nxt = s_r;
		unique case (s_r.st)
			PSS_IDLE: begin
				// A fresh enable always starts from the initial codes.
				s_nxt.up_code = CODE_ZERO; // see (RL5)
				s_nxt.dn_code = CODE_FULL; // see (RL5)
				s_nxt.step_n = 7'h00;
				s_nxt.div = '0;
				if (ref_ok) begin
					s_nxt.st = PSS_RAMP; // see (RL1)
				end
			end
			PSS_RAMP: begin
				// One code step each STEP_CYCLES clocks, 128 steps in all.
				if (div_done(s_r.div)) begin
					s_nxt.div = '0; // see (RL17)
					s_nxt.up_code = s_r.up_code + 7'h01; // see (RL2)
					// Floor reached after 128 steps; interpolated linearly.
					s_nxt.dn_code = 7'(CODE_FULL - 7'((14'(s_r.step_n + 7'h01)
						* 14'(CODE_FULL - CODE_LOW_FLOOR)) >> 7)); // see (RL3)
					s_nxt.step_n = s_r.step_n + 7'h01;
					if (s_r.step_n == STEP_LAST) begin
						s_nxt.up_code = CODE_FULL;
						s_nxt.dn_code = CODE_LOW_FLOOR;
						s_nxt.st = PSS_WAIT_REG; // see (RL4)
					end
				end else begin
					s_nxt.div = s_r.div + DIV_W'(1);
				end
			end
			PSS_WAIT_REG: begin
				if (all_ok) begin
					s_nxt.st = PSS_DELAY; // see (RL6)
				end
			end
			PSS_DELAY: begin
				if (del_ok) begin
					s_nxt.st = PSS_RUN; // see (RL7)
				end
			end
			PSS_RUN: begin
			end
			PSS_FAULT: begin
			end
			default: begin
				s_nxt.st = PSS_FAULT;
			end
		endcase

		// Fault timer runs only once ramps are complete; it restarts when faults clear.
		if (s_r.st == PSS_WAIT_REG || s_r.st == PSS_DELAY || s_r.st == PSS_RUN) begin
			if (any_low) begin
				s_nxt.ftim = s_r.ftim + FT_W'(1); // see (RL11)
			end else begin
				s_nxt.ftim = '0;
			end
		end else begin
			s_nxt.ftim = '0; // see (RL14)
		end
		if ((s_r.st == PSS_WAIT_REG || s_r.st == PSS_DELAY || s_r.st == PSS_RUN)
			&& any_low && s_r.ftim == FT_W'(FAULT_CYCLES - 1)) begin
			s_nxt.fault = 1'b1; // see (RL12)
		end
		if (hot) begin
			s_nxt.fault = 1'b1; // see (RL15)
		end
		// Latch is sticky; only the lockout reset clears it.
		if (s_nxt.fault) begin
			s_nxt.st = PSS_FAULT; // see (RL13)
		end

		// Steering sampled only with all enabling conditions met.
		if (steer_ok) begin
			s_nxt.hs = steer; // see (RL10)
			s_nxt.ls = ~steer; // see (RL10)
		end else begin
			s_nxt.hs = 1'b0;
			s_nxt.ls = 1'b0;
		end
		if (s_nxt.st != PSS_RUN) begin
			s_nxt.hs = 1'b0;
			s_nxt.ls = 1'b0;
		end
	end

	// Steering also waits on the delay level itself, so a sagging delay node opens the switches.
	assign steer_ok = (s_r.st == PSS_RUN) && !s_r.fault && del_ok; // see (RL9)

	// State register; clock enable freezes everything.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= '{st: PSS_IDLE, up_code: CODE_ZERO, dn_code: CODE_FULL,
				step_n: 7'h00, div: '0, ftim: '0, fault: 1'b0, hs: 1'b0, ls: 1'b0};
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	// Outputs decoded from the registered state.
	assign stepup_en_o = s_r.st inside {PSS_RAMP, PSS_WAIT_REG, PSS_DELAY, PSS_RUN}; // see (RL16)
	assign gate_high_en_o = stepup_en_o; // see (RL1)
	assign gate_low_en_o = stepup_en_o;
	assign stepup_code_o = s_r.up_code;
	assign gate_high_code_o = s_r.up_code;
	assign gate_low_code_o = s_r.dn_code;
	// Node is grounded in every state before the regulators are confirmed.
	assign delay_cap_node_short_o = !(s_r.st inside {PSS_DELAY, PSS_RUN}); // see (RL8)
	assign delay_charge_en_o = s_r.st inside {PSS_DELAY, PSS_RUN}; // see (RL6)
	assign switch_block_en_o = s_r.st == PSS_RUN; // see (RL7)
	assign amp_en_o = s_r.st == PSS_RUN;
	assign amp_hiz_o = s_r.st != PSS_RUN; // see (RL16)
	assign high_side_switch_o = s_r.hs;
	assign low_side_switch_o = s_r.ls;
	assign fault_latched_o = s_r.fault;

	// Enable never lasts past a fault.
	chk_fault_kills_en: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL12)
		fault_latched_o |-> !stepup_en_o && !switch_block_en_o && amp_hiz_o)
		else $error("outputs on with fault latched");
	// Only the lockout reset drops the latch; eight cycles stand in for ever.
	chk_fault_sticky: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL13)
		$rose(fault_latched_o) |=> fault_latched_o [*8])
		else $error("fault latch cleared without reset");
	// The latch rises only from heat or from a full fault interval.
	chk_fault_cause: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL12)
		$rose(fault_latched_o) |->
		$past(hot) || $past(s_r.ftim) == FT_W'(FAULT_CYCLES - 1))
		else $error("fault latched without cause");
	// Ramps must keep the delay node grounded.
	chk_ramp_short: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL4)
		s_r.st == PSS_RAMP |-> delay_cap_node_short_o)
		else $error("delay node released during ramp");
	// A new enable shows the initial codes.
	chk_ramp_start: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL5)
		$rose(stepup_en_o) |-> stepup_code_o == CODE_ZERO && gate_low_code_o == CODE_FULL)
		else $error("ramp did not restart");
	// Idle always holds the initial codes ready for the next enable.
	chk_idle_codes: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL5)
		s_r.st == PSS_IDLE |-> stepup_code_o == CODE_ZERO && gate_low_code_o == CODE_FULL)
		else $error("idle codes wrong");
	// The last step lands exactly on the end codes.
	chk_ramp_end: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL3)
		$past(s_r.st) == PSS_RAMP && s_r.st == PSS_WAIT_REG |->
		stepup_code_o == CODE_FULL && gate_low_code_o == CODE_LOW_FLOOR)
		else $error("ramp end codes wrong");
	// Gate-low code only falls during the ramp.
	chk_low_down: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL3)
		ce_i && s_r.st == PSS_RAMP |=> gate_low_code_o <= $past(gate_low_code_o))
		else $error("gate-low code rose during ramp");
	// The floor code is the lowest the gate-low code ever shows.
	chk_low_floor: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL3)
		gate_low_code_o >= CODE_LOW_FLOOR)
		else $error("gate-low code under its floor");
	// Up codes climb by one step at a time.
	chk_up_step: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL2)
		ce_i && s_r.st == PSS_RAMP && s_nxt.st == PSS_RAMP |=>
		stepup_code_o == $past(stepup_code_o)
		|| stepup_code_o == $past(stepup_code_o) + 7'h01)
		else $error("up code skipped a step");
	// Steps fall only on the divider's terminal count, which sets the ramp length.
	chk_step_rate: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL4)
		ce_i && s_r.st == PSS_RAMP && !div_done(s_r.div) |=> $stable(stepup_code_o))
		else $error("ramp stepped off the divider");
	// Heat latches the fault on the next enabled edge.
	chk_hot_latch: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL15)
		ce_i && syn[0] |=> fault_latched_o)
		else $error("over-temperature did not latch");
	// Switches stay open unless every steering condition held.
	chk_steer_gate: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL9)
		(high_side_switch_o || low_side_switch_o) |-> switch_block_en_o && $past(del_ok))
		else $error("steering active too early");
	// With steering live the pair follows the input, one closed and one open.
	chk_steer_excl: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL10)
		ce_i && s_r.st == PSS_RUN && s_nxt.st == PSS_RUN && del_ok |=>
		high_side_switch_o == $past(switch_steer_i) && low_side_switch_o == !high_side_switch_o)
		else $error("switch pair wrong");
	// Both switches closed at once would short the two switch inputs together.
	chk_switch_break: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL10)
		!(high_side_switch_o && low_side_switch_o))
		else $error("both switches closed");
	// The timer stays clear during ramps.
	chk_no_timer_ramp: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL14)
		s_r.st == PSS_RAMP |-> s_r.ftim == '0)
		else $error("fault timer ran during ramp");
	// Healthy outputs keep the timer at zero, so only a continuous fault can latch.
	chk_timer_clear: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL11)
		ce_i && !any_low |=> s_r.ftim == '0)
		else $error("fault timer kept counting");
	// All three regulators share one enable.
	chk_all_enable: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL1)
		stepup_en_o == gate_high_en_o && gate_high_en_o == gate_low_en_o)
		else $error("regulator enables split");
	// The synchronised reference moves idle straight to the ramp.
	chk_ref_enables: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL1)
		ce_i && s_r.st == PSS_IDLE && ref_ok && !hot |=> stepup_en_o && gate_low_en_o)
		else $error("reference did not enable regulators");
	// Charging starts only after all three report regulation.
	chk_release_ok: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL6)
		$rose(delay_charge_en_o) |-> $past(all_ok))
		else $error("delay node released before regulation");
	// A released node always goes with charging and no fault.
	chk_node_release: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL8)
		!delay_cap_node_short_o |-> delay_charge_en_o && !fault_latched_o)
		else $error("delay node released out of sequence");
	// Amplifiers turn on only after the delay level was seen.
	chk_amp_on_del: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL7)
		$rose(amp_en_o) |-> $past(del_ok))
		else $error("amplifiers on before delay level");
	// A low enable freezes every register, synchroniser included.
	chk_ce_freeze: assert property (@(posedge clk_i) disable iff (!nrst_i) // see (RL17)
		!ce_i |=> $stable(s_r) && $stable(syn))
		else $error("state moved with clock enable low");
endmodule // pss_sequencer
`default_nettype wire

// *** verif/pss_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the regulators and the delay comparator.
module pss_analog_model #(
	parameter int unsigned REG_DLY = 6,
	parameter int unsigned DEL_DLY = 9
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic stepup_en_i,
	input wire logic gate_high_en_i,
	input wire logic gate_low_en_i,
	input wire logic short_i,
	input wire logic charge_i,
	input wire logic sag_i,
	output logic stepup_ok_o,
	output logic gate_high_ok_o,
	output logic gate_low_ok_o,
	output logic delay_reached_o
);
	logic [7:0] reg_cnt_r;
	logic [7:0] del_cnt_r;
	logic reg_up;
	// Outputs settle a while after enable; the cap charges only once released.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_cnt_r <= 8'h00;
			del_cnt_r <= 8'h00;
		end else begin
			reg_cnt_r <= !stepup_en_i ? 8'h00 : (reg_up ? reg_cnt_r : reg_cnt_r + 8'h01);
			del_cnt_r <= (short_i || !charge_i) ? 8'h00 : del_cnt_r + {7'h00, !delay_reached_o};
		end
	end
	// A sag pulls the step-up output under its fault threshold.
	assign reg_up = reg_cnt_r >= 8'(REG_DLY);
	assign stepup_ok_o = stepup_en_i && reg_up && !sag_i;
	assign gate_high_ok_o = gate_high_en_i && reg_up;
	assign gate_low_ok_o = gate_low_en_i && reg_up;
	assign delay_reached_o = del_cnt_r >= 8'(DEL_DLY);
endmodule // pss_analog_model
`default_nettype wire

// *** verif/pss_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_tb;
	localparam int unsigned STEP = 4;
	localparam int unsigned FLT = 20;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic rdy = 1'b0;
	logic hot = 1'b0;
	logic steer = 1'b0;
	logic sag = 1'b0;
	logic want = 1'b0;
	logic ce = 1'b1;
	logic su_ok, gh_ok, gl_ok, del_ok, su_en, gh_en, gl_en, sh, chg, swb, amp, hiz, hs, ls, flt;
	logic [6:0] su_c, gh_c, gl_c;
	logic [31:0] seed = 32'h1B30BB28;
	logic [21:0] q[$];
	logic [21:0] e;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	int t0 = 0;
	wire logic [10:0] obs = {su_en, gh_en, gl_en, sh, chg, swb, amp, hiz, hs, ls, flt};
	always #12.5 clk_i = ~clk_i;
	pss_sequencer #(.STEP_CYCLES(STEP), .FAULT_CYCLES(FLT)) i_pss_sequencer (.clk_i(clk_i),
		.nrst_i(nrst_i), .ce_i(ce), .ref_ready_i(rdy), .stepup_ok_i(su_ok),
		.gate_high_ok_i(gh_ok), .gate_low_ok_i(gl_ok), .delay_reached_i(del_ok),
		.over_temp_i(hot), .switch_steer_i(steer), .stepup_en_o(su_en), .gate_high_en_o(gh_en),
		.gate_low_en_o(gl_en), .stepup_code_o(su_c), .gate_high_code_o(gh_c),
		.gate_low_code_o(gl_c), .delay_cap_node_short_o(sh), .delay_charge_en_o(chg),
		.switch_block_en_o(swb), .amp_en_o(amp), .amp_hiz_o(hiz), .high_side_switch_o(hs),
		.low_side_switch_o(ls), .fault_latched_o(flt));
	pss_analog_model i_pss_analog_model (.clk_i(clk_i), .nrst_i(nrst_i), .stepup_en_i(su_en),
		.gate_high_en_i(gh_en), .gate_low_en_i(gl_en), .short_i(sh), .charge_i(chg),
		.sag_i(sag), .stepup_ok_o(su_ok), .gate_high_ok_o(gh_ok), .gate_low_ok_o(gl_ok),
		.delay_reached_o(del_ok));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// The mask leaves out outputs whose level the rules leave open.
	task automatic note(input logic [10:0] exp, input logic [10:0] msk);
		@(posedge clk_i);
		q.push_back({exp, msk});
		want <= 1'b1;
		@(posedge clk_i);
		want <= 1'b0;
	endtask
	// Bounded wait: 0 enables up, 1 node released, 2 amplifiers on.
	task automatic wait_on(input int k);
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk_i);
			#1;
			if ((k == 0 && su_en === 1'b1) || (k == 1 && sh === 1'b0) || (k == 2 && amp === 1'b1))
				return;
		end
		n_errors++;
		report_and_stop();
	endtask
	// Watcher: the oldest note is compared when its strobe shows.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (want) begin
			e = q.pop_front();
			check(32'(obs & e[10:0]), 32'(e[21:11]));
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		note(11'h088, 11'h7FF);
		rdy <= 1'b1;
		wait_on(0);
		t0 = cyc;
		check(32'({su_c, gh_c, gl_c}), 32'h0000007F);
		note(11'h788, 11'h7FF);
		wait_on(1);
		check(32'(cyc - t0 >= 128 * STEP && cyc - t0 <= 128 * STEP + 3), 32'h00000001);
		check(32'({su_c, gh_c, gl_c}), 32'h001FFF99);
		note(11'h748, 11'h7FF);
		wait_on(2);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			@(posedge clk_i);
			steer <= seed[0];
			repeat (2) @(posedge clk_i);
			note(11'h770 | {8'h00, seed[0], ~seed[0], 1'b0}, 11'h7FF);
		end
		sag <= 1'b1;
		repeat (FLT + 8) @(posedge clk_i);
		steer <= ~steer;
		repeat (2) @(posedge clk_i);
		note(11'h001, 11'h737);
		nrst_i <= 1'b0;
		sag <= 1'b0;
		rdy <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		note(11'h088, 11'h7FF);
		rdy <= 1'b1;
		wait_on(0);
		check(32'({su_c, gh_c, gl_c}), 32'h0000007F);
		@(posedge clk_i);
		// A frozen ramp must still show its start codes after many clocks.
		ce <= 1'b0;
		repeat (12) @(posedge clk_i);
		check(32'({su_c, gh_c, gl_c}), 32'h0000007F);
		ce <= 1'b1;
		sag <= 1'b1;
		repeat (3 * FLT) @(posedge clk_i);
		note(11'h700, 11'h701);
		sag <= 1'b0;
		hot <= 1'b1;
		repeat (6) @(posedge clk_i);
		note(11'h001, 11'h737);
		repeat (3) @(posedge clk_i);
		report_and_stop();
	end
endmodule // pss_sequencer_tb
`default_nettype wire
